// >>> smmu_two_stage_translation.sv
// seven translation buffer units sharing one table walk controller
`timescale 1ns/100ps
`include "smmu_map.svh"
module smmu_two_stage_translation (
  input  wire logic                                 clock,
  input  wire logic                                 reset_n,
  input  wire logic [`SMMU_UNITS-1:0]               up_valid,
  input  wire smmu_pkg::up_req_type [`SMMU_UNITS-1:0] up_req,
  output      logic [`SMMU_UNITS-1:0]               up_ready,
  input  wire logic                                 alt_valid,
  input  wire smmu_pkg::up_req_type                 alt_req,
  output      logic                                 alt_ready,
  output      logic [`SMMU_UNITS-1:0]               down_valid,
  output      smmu_pkg::down_req_type [`SMMU_UNITS-1:0] down_req,
  input  wire logic [`SMMU_UNITS-1:0]               down_ready,
  output      logic [`SMMU_UNITS-1:0]               err_valid,
  output      smmu_pkg::err_type [`SMMU_UNITS-1:0]  err_info,
  input  wire logic [`SMMU_UNITS-1:0]               err_ready,
  output      logic                                 table_req_valid,
  output      smmu_pkg::table_req_type              table_req,
  input  wire logic                                 table_req_ready,
  input  wire logic                                 table_rsp_valid,
  input  wire smmu_pkg::table_rsp_type              table_rsp
);
  import smmu_pkg::*;

  // ==========================================================
  // helpers
  // first valid entry matching stream id and page: {hit, index}
  function automatic logic [`SMMU_TLB_IDX_W:0] tlb_find(
    input tlb_set_type              set,
    input logic [`SMMU_SID_W-1:0]   sid,
    input logic [`SMMU_VPAGE_W-1:0] vpage);
    logic [`SMMU_TLB_IDX_W:0] res;
    res = '0;
    for (int e = `SMMU_TLB_DEPTH - 1; e >= 0; e--) begin
      if (set[e].valid && set[e].sid == sid && set[e].vpage == vpage) begin
        res = {1'b1, e[`SMMU_TLB_IDX_W-1:0]};
      end
    end
    return res;
  endfunction : tlb_find

  // fixed destination per unit, two units decide by address
  function automatic dest_type dest_of(input int unit, input logic [`SMMU_PA_W-1:0] pa);
    dest_type d;
    case (unit)
      0:       d = dest_coh_s3;
      1:       d = dest_coh_s2;
      2:       d = dest_coh_s1;
      3:       d = (pa[`SMMU_PA_W-1:`SMMU_MSI_TAG_LSB] == `SMMU_MSI_TAG)
                   ? dest_msi : dest_coh_s0;
      4:       d = dest_main_feed;
      5:       d = (pa[`SMMU_PA_W-1:`SMMU_MAIN_TAG_LSB] == `SMMU_MAIN_TAG)
                   ? dest_main_switch : dest_noc_egress;
      default: d = dest_noc_egress;
    endcase
    return d;
  endfunction : dest_of

  // ==========================================================
  // reset release through two flops
  logic rst_meta_q;
  logic rst_sync_n;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_n <= rst_meta_q;
    end
  end

  // ==========================================================
  // links between units and the walker
  logic [`SMMU_UNITS-1:0]       walk_want;
  tlb_entry_type [`SMMU_UNITS-1:0] walk_key;
  logic [`SMMU_UNITS-1:0]       fill_valid;
  logic                         fill_fault;
  tlb_entry_type                fill_entry;

  // ==========================================================
  // translation buffer units
  for (genvar u = 0; u < `SMMU_UNITS; u++) begin : g_unit
    unit_state_type              state_q, state_d;
    up_req_type                  req_q, req_d;
    logic [`SMMU_SID_W-1:0]      sid_q, sid_d;
    tlb_set_type                 tlb_q, tlb_d;
    logic [`SMMU_TLB_IDX_W-1:0]  repl_q, repl_d;
    down_req_type                out_q, out_d;
    err_type                     err_q, err_d;
    logic [`SMMU_TLB_IDX_W:0]    look;
    tlb_entry_type               hit_e;
    logic                        take_alt;
    logic                        allowed;

    // unit 2 also takes the noc ingress source, primary port first
    assign take_alt = (u == `SMMU_UNIT_PRIMARY) && alt_valid && !up_valid[u];
    assign look     = tlb_find(tlb_q, sid_q, req_q.va[`SMMU_VA_W-1:`SMMU_PAGE_LSB]);
    assign hit_e    = tlb_q[look[`SMMU_TLB_IDX_W-1:0]];
    assign allowed  = req_q.write ? hit_e.wr_ok : hit_e.rd_ok;

    // request flow: accept, look up, walk on miss, forward or fault
    always_comb begin
      state_d = state_q;
      req_d   = req_q;
      sid_d   = sid_q;
      out_d   = out_q;
      err_d   = err_q;
      case (state_q)
        u_idle: begin
          if (up_valid[u] || take_alt) begin
            req_d   = take_alt ? alt_req : up_req[u];
            // unit code above master id forms the stream id
            sid_d   = {`SMMU_CODE_W'(u), req_d.master_id};
            state_d = u_lookup;
          end
        end
        u_lookup: begin
          if (!look[`SMMU_TLB_IDX_W]) begin
            state_d = u_walk;
          end else if (allowed) begin
            // only the cached physical page goes out
            out_d.pa        = {hit_e.ppage, req_q.va[`SMMU_PAGE_LSB-1:0]};
            out_d.stream_id = sid_q;
            out_d.write     = req_q.write;
            out_d.secure    = hit_e.secure;
            out_d.dest      = dest_of(u, out_d.pa);
            state_d         = u_send;
          end else begin
            err_d   = '{master_id: req_q.master_id, write: req_q.write};
            state_d = u_fault;
          end
        end
        u_walk: begin
          // re-lookup after the fill rather than bypassing the cache
          if (fill_valid[u]) begin
            if (fill_fault) begin
              err_d   = '{master_id: req_q.master_id, write: req_q.write};
              state_d = u_fault;
            end else begin
              state_d = u_lookup;
            end
          end
        end
        u_send: begin
          if (down_ready[u]) begin
            state_d = u_idle;
          end
        end
        u_fault: begin
          if (err_ready[u]) begin
            state_d = u_idle;
          end
        end
        default: state_d = u_idle;
      endcase
    end

    // cache fill, round-robin victim; only the walker writes here
    always_comb begin
      tlb_d  = tlb_q;
      repl_d = repl_q;
      if (fill_valid[u] && !fill_fault) begin
        tlb_d[repl_q] = fill_entry;
        repl_d        = repl_q + 1'b1;
      end
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        state_q <= u_idle;
        req_q   <= '0;
        sid_q   <= '0;
        out_q   <= '0;
        err_q   <= '0;
        tlb_q   <= '0;
        repl_q  <= '0;
      end else begin
        state_q <= state_d;
        req_q   <= req_d;
        sid_q   <= sid_d;
        out_q   <= out_d;
        err_q   <= err_d;
        tlb_q   <= tlb_d;
        repl_q  <= repl_d;
      end
    end

    // handshakes combinational, data straight from flops
    assign up_ready[u]  = (state_q == u_idle);
    assign walk_want[u] = (state_q == u_walk);
    assign walk_key[u]  = '{valid: 1'b1, sid: sid_q, vpage: req_q.va[`SMMU_VA_W-1:`SMMU_PAGE_LSB],
                            ppage: '0, rd_ok: 1'b0, wr_ok: 1'b0, secure: 1'b0};
    assign down_valid[u] = (state_q == u_send);
    assign down_req[u]   = out_q;
    assign err_valid[u]  = (state_q == u_fault);
    assign err_info[u]   = err_q;
  end

  // unit 2 alternate source sees ready only when the primary is quiet
  assign alt_ready = up_ready[`SMMU_UNIT_PRIMARY] && !up_valid[`SMMU_UNIT_PRIMARY];

  // ==========================================================
  // shared table walk controller
  walk_state_type                wstate_q, wstate_d;
  logic [`SMMU_UNIT_IDX_W-1:0]   owner_q, owner_d;
  logic [`SMMU_UNIT_IDX_W-1:0]   last_q, last_d;
  logic                          sent_q, sent_d;
  tlb_entry_type                 work_q, work_d;
  logic [`SMMU_VPAGE_W-1:0]      mid_q, mid_d;
  logic                          fault_q, fault_d;

  // round-robin grant so no unit is starved behind a busy one
  function automatic logic [`SMMU_UNIT_IDX_W:0] rr_pick(
    input logic [`SMMU_UNITS-1:0]     want,
    input logic [`SMMU_UNIT_IDX_W-1:0] last);
    logic [`SMMU_UNIT_IDX_W:0] res;
    int                        idx;
    res = '0;
    for (int k = `SMMU_UNITS; k >= 1; k--) begin
      idx = (int'(last) + k) % `SMMU_UNITS;
      if (want[idx]) begin
        res = {1'b1, idx[`SMMU_UNIT_IDX_W-1:0]};
      end
    end
    return res;
  endfunction : rr_pick

  logic [`SMMU_UNIT_IDX_W:0] pick;
  assign pick = rr_pick(walk_want, last_q);

  always_comb begin
    wstate_d = wstate_q;
    owner_d  = owner_q;
    last_d   = last_q;
    sent_d   = sent_q;
    work_d   = work_q;
    mid_d    = mid_q;
    fault_d  = fault_q;
    if ((wstate_q == w_stage1 || wstate_q == w_stage2) && !sent_q && table_req_ready) begin
      sent_d = 1'b1;
    end
    case (wstate_q)
      w_idle: begin
        if (pick[`SMMU_UNIT_IDX_W]) begin
          owner_d  = pick[`SMMU_UNIT_IDX_W-1:0];
          last_d   = pick[`SMMU_UNIT_IDX_W-1:0];
          work_d   = walk_key[pick[`SMMU_UNIT_IDX_W-1:0]];
          fault_d  = 1'b0;
          sent_d   = 1'b0;
          wstate_d = w_stage1;
        end
      end
      w_stage1: begin
        if (sent_q && table_rsp_valid) begin
          sent_d = 1'b0;
          // guest table gives intermediate page and context attributes
          mid_d        = table_rsp.page;
          work_d.rd_ok = table_rsp.rd_ok;
          work_d.wr_ok = table_rsp.wr_ok;
          work_d.secure = table_rsp.secure;
          fault_d      = !table_rsp.mapped;
          wstate_d     = table_rsp.mapped ? w_stage2 : w_fill;
        end
      end
      w_stage2: begin
        if (sent_q && table_rsp_valid) begin
          sent_d = 1'b0;
          // hypervisor table; pages beyond 44 bits count as unmapped
          work_d.ppage = table_rsp.page[`SMMU_PPAGE_W-1:0];
          work_d.rd_ok = work_q.rd_ok && table_rsp.rd_ok;
          work_d.wr_ok = work_q.wr_ok && table_rsp.wr_ok;
          fault_d      = !table_rsp.mapped ||
                         (table_rsp.page[`SMMU_VPAGE_W-1:`SMMU_PPAGE_W] != '0);
          wstate_d     = w_fill;
        end
      end
      w_fill: wstate_d = w_idle;
      default: wstate_d = w_idle;
    endcase
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wstate_q <= w_idle;
      owner_q  <= '0;
      last_q   <= '0;
      sent_q   <= 1'b0;
      work_q   <= '0;
      mid_q    <= '0;
      fault_q  <= 1'b0;
    end else begin
      wstate_q <= wstate_d;
      owner_q  <= owner_d;
      last_q   <= last_d;
      sent_q   <= sent_d;
      work_q   <= work_d;
      mid_q    <= mid_d;
      fault_q  <= fault_d;
    end
  end

  // table port: stage chosen by state, page is va or intermediate
  assign table_req_valid = (wstate_q == w_stage1 || wstate_q == w_stage2) && !sent_q;
  assign table_req.stage = (wstate_q == w_stage2);
  assign table_req.sid   = work_q.sid;
  assign table_req.page  = (wstate_q == w_stage2) ? mid_q : work_q.vpage;

  // one-cycle fill pulse to the owning unit
  always_comb begin
    fill_valid = '0;
    if (wstate_q == w_fill) begin
      fill_valid[owner_q] = 1'b1;
    end
  end
  assign fill_fault = fault_q;
  assign fill_entry = work_q;

endmodule : smmu_two_stage_translation

// >>> smmu_map.svh
// constants for the two-stage translation block
`ifndef SMMU_MAP_SVH
`define SMMU_MAP_SVH
`define SMMU_UNITS 7
`define SMMU_VA_W 48
`define SMMU_PA_W 44
`define SMMU_SID_W 15
`define SMMU_MASTER_ID_W 10
`define SMMU_CODE_W 5
`define SMMU_CODE_LSB 10
`define SMMU_PAGE_LSB 12
`define SMMU_VPAGE_W 36
`define SMMU_PPAGE_W 32
`define SMMU_TLB_DEPTH 4
`define SMMU_TLB_IDX_W 2
`define SMMU_UNIT_IDX_W 3
`define SMMU_UNIT_PRIMARY 2
`define SMMU_UNIT_MSI 3
`define SMMU_UNIT_SPLIT 5
`define SMMU_MSI_TAG_LSB 20
`define SMMU_MSI_TAG 24'h00F_E000
`define SMMU_MAIN_TAG_LSB 32
`define SMMU_MAIN_TAG 12'h000
`endif

// >>> smmu_pkg.sv
// types shared by the two-stage translation block
`include "smmu_map.svh"
package smmu_pkg;
  // downstream target of a translated transaction
  typedef enum logic [2:0] {
    dest_coh_s3, dest_coh_s2, dest_coh_s1, dest_coh_s0,
    dest_msi, dest_main_feed, dest_main_switch, dest_noc_egress
  } dest_type;
  typedef struct packed {
    logic [`SMMU_VA_W-1:0]        va;
    logic [`SMMU_MASTER_ID_W-1:0] master_id;
    logic                         write;
  } up_req_type;
  typedef struct packed {
    logic [`SMMU_PA_W-1:0]  pa;
    logic [`SMMU_SID_W-1:0] stream_id;
    logic                   write;
    logic                   secure;
    dest_type               dest;
  } down_req_type;
  typedef struct packed {
    logic [`SMMU_MASTER_ID_W-1:0] master_id;
    logic                         write;
  } err_type;
  typedef struct packed {
    logic                     valid;
    logic [`SMMU_SID_W-1:0]   sid;
    logic [`SMMU_VPAGE_W-1:0] vpage;
    logic [`SMMU_PPAGE_W-1:0] ppage;
    logic                     rd_ok;
    logic                     wr_ok;
    logic                     secure;
  } tlb_entry_type;
  typedef tlb_entry_type [`SMMU_TLB_DEPTH-1:0] tlb_set_type;
  // stage 0 = guest table (va to intermediate), stage 1 = hypervisor table
  typedef struct packed {
    logic                     stage;
    logic [`SMMU_SID_W-1:0]   sid;
    logic [`SMMU_VPAGE_W-1:0] page;
  } table_req_type;
  typedef struct packed {
    logic                     mapped;
    logic [`SMMU_VPAGE_W-1:0] page;
    logic                     rd_ok;
    logic                     wr_ok;
    logic                     secure;
  } table_rsp_type;
  typedef enum logic [2:0] {
    u_idle = 3'h0, u_lookup = 3'h1, u_walk = 3'h3, u_send = 3'h2, u_fault = 3'h6
  } unit_state_type;
  typedef enum logic [1:0] {
    w_idle = 2'h0, w_stage1 = 2'h1, w_stage2 = 2'h3, w_fill = 2'h2
  } walk_state_type;
endpackage : smmu_pkg

// >>> smmu_two_stage_translation_assertions.sv
// port checker for the two-stage translation block
`timescale 1ns/100ps
`include "smmu_map.svh"
module smmu_two_stage_translation_assertions (
  input wire logic                                     clock,
  input wire logic                                     reset_n,
  input wire logic [`SMMU_UNITS-1:0]                   up_valid,
  input wire smmu_pkg::up_req_type [`SMMU_UNITS-1:0]   up_req,
  input wire logic [`SMMU_UNITS-1:0]                   up_ready,
  input wire logic                                     alt_valid,
  input wire smmu_pkg::up_req_type                     alt_req,
  input wire logic                                     alt_ready,
  input wire logic [`SMMU_UNITS-1:0]                   down_valid,
  input wire smmu_pkg::down_req_type [`SMMU_UNITS-1:0] down_req,
  input wire logic [`SMMU_UNITS-1:0]                   down_ready,
  input wire logic [`SMMU_UNITS-1:0]                   err_valid,
  input wire smmu_pkg::err_type [`SMMU_UNITS-1:0]      err_info,
  input wire logic [`SMMU_UNITS-1:0]                   err_ready,
  input wire logic                                     table_req_valid,
  input wire smmu_pkg::table_req_type                  table_req,
  input wire logic                                     table_req_ready,
  input wire logic                                     table_rsp_valid,
  input wire smmu_pkg::table_rsp_type                  table_rsp
);
  import smmu_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // =========================================
  // helper: master id taken on unit 0
  logic [`SMMU_MASTER_ID_W-1:0] id0_q;
  always_ff @(posedge clock) begin
    if (up_valid[0] && up_ready[0]) id0_q <= up_req[0].master_id;
  end
  // =========================================
  // per-unit handshake and tagging
  for (genvar u = 0; u < `SMMU_UNITS; u++) begin : g_unit
    sid_code_a: assert property (down_valid[u] |-> down_req[u].stream_id[14:10] == u)
      else $error("unit code wrong in stream id");
    down_hold_a: assert property (down_valid[u] && !down_ready[u] |=> down_valid[u] && $stable(down_req[u]))
      else $error("forwarded request dropped or changed");
    err_hold_a: assert property (err_valid[u] && !err_ready[u] |=> err_valid[u] && $stable(err_info[u]))
      else $error("slave error dropped or changed");
    busy_refuse_a: assert property (down_valid[u] || err_valid[u] |-> !up_ready[u])
      else $error("unit ready while answer pending");
    taken_quiet_a: assert property (up_valid[u] && up_ready[u] |=> !down_valid[u] && !err_valid[u])
      else $error("answer in the cycle after take");
  end
  // =========================================
  // routing, walk port and source choice
  msi_route_a: assert property (down_valid[3] |-> down_req[3].dest == (down_req[3].pa[43:20] == `SMMU_MSI_TAG ? dest_msi : dest_coh_s0))
    else $error("unit 3 route wrong");
  split_route_a: assert property (down_valid[5] |-> down_req[5].dest == (down_req[5].pa[43:32] == `SMMU_MAIN_TAG ? dest_main_switch : dest_noc_egress))
    else $error("unit 5 route wrong");
  fixed_dest_a: assert property ((!down_valid[0] || down_req[0].dest == dest_coh_s3) && (!down_valid[2] || down_req[2].dest == dest_coh_s1) && (!down_valid[4] || down_req[4].dest == dest_main_feed))
    else $error("fixed route wrong");
  alt_yield_a: assert property (alt_ready |-> up_ready[2] && !up_valid[2])
    else $error("second source not yielding");
  table_hold_a: assert property (table_req_valid && !table_req_ready |=> table_req_valid && $stable(table_req))
    else $error("walk request dropped or changed");
  id_pass_a: assert property (down_valid[0] |-> down_req[0].stream_id[9:0] == id0_q)
    else $error("master id not passed through");
endmodule : smmu_two_stage_translation_assertions
bind smmu_two_stage_translation smmu_two_stage_translation_assertions i_chk (.*);

// >>> table_walk_model.sv
// table memory model answering the block's walk requests
`timescale 1ns/100ps
module table_walk_model (
  input  wire logic                    clock,
  input  wire logic                    reset_n,
  input  wire logic                    slow,
  input  wire logic                    table_req_valid,
  input  wire smmu_pkg::table_req_type table_req,
  output      logic                    table_req_ready,
  output      logic                    table_rsp_valid,
  output      smmu_pkg::table_rsp_type table_rsp
);
  import smmu_pkg::*;
  logic          busy_q;
  int            wait_q;
  table_req_type held_q;
  // =========================================
  // contents: page bit 7 a hole, bit 6 read-only, bit 4 secure
  function automatic table_rsp_type lookup(input table_req_type r);
    table_rsp_type a;
    a.mapped = !r.page[7];
    a.rd_ok  = 1'b1;
    a.wr_ok  = !r.page[6];
    a.secure = r.page[4];
    // guest step flips bit 0, hypervisor step bit 8, so a skipped stage shows
    a.page   = r.stage ? {4'h0, r.page[31:0] ^ 32'h0000_0100} : r.page ^ 36'h0_0000_0001;
    return a;
  endfunction : lookup
  // =========================================
  // one step at a time, answered after two or seven idle cycles
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      busy_q <= 1'b0;
      wait_q <= 0;
      held_q <= '0;
      table_req_ready <= 1'b0;
      table_rsp_valid <= 1'b0;
      table_rsp <= '0;
    end else begin
      table_rsp_valid <= 1'b0;
      table_rsp <= ~table_rsp; // stale answer changes every cycle
      if (busy_q) begin
        wait_q <= wait_q - 1;
        if (wait_q == 0) begin
          busy_q <= 1'b0;
          table_rsp_valid <= 1'b1;
          table_rsp <= lookup(held_q);
        end
      end else if (table_req_valid && table_req_ready) begin
        busy_q <= 1'b1;
        held_q <= table_req;
        wait_q <= slow ? 6 : 1;
        table_req_ready <= 1'b0;
      end else begin
        table_req_ready <= table_req_valid; // ready a cycle after the request shows
      end
    end
  end
endmodule : table_walk_model

// >>> smmu_two_stage_translation_bench.sv
// self-checking bench for the two-stage translation block
`timescale 1ns/100ps
`include "smmu_map.svh"
module smmu_two_stage_translation_bench;
  import smmu_pkg::*;
  logic          clock = 0, reset_n = 0, slow = 0, alt_valid = 0, alt_ready, got_err;
  logic [6:0]    up_valid = 0, up_ready, down_valid, down_ready = 0, err_valid, err_ready = 0;
  up_req_type    [6:0] up_req = '0;
  down_req_type  [6:0] down_req;
  err_type       [6:0] err_info;
  up_req_type    alt_req = '0;
  logic          table_req_valid, table_req_ready, table_rsp_valid;
  table_req_type table_req;
  table_rsp_type table_rsp;
  down_req_type  seen;
  err_type       einfo;
  int            bad_count = 0, n_tests = 0, walks = 0, lat;
  always #2 clock = ~clock;
  // walk steps accepted, to tell hits from misses
  always @(posedge clock) if (table_req_valid && table_req_ready) walks <= walks + 1;
  smmu_two_stage_translation i_dut (.*);
  table_walk_model i_walk (.*);
  // =========================================
  // shared tasks
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  // wait for the answer, hold it off for stall cycles, then take it
  task automatic collect(input int u, input int stall);
    lat = 0;
    do begin @(negedge clock); lat++; end while (!down_valid[u] && !err_valid[u] && lat < 500);
    got_err = err_valid[u];
    seen = down_req[u];
    einfo = err_info[u];
    check(lat < 500, 1'b1);
    repeat (stall) @(negedge clock);
    if (!got_err) check(down_req[u], seen);
    @(posedge clock);
    down_ready[u] <= !got_err;
    err_ready[u] <= got_err;
    @(posedge clock);
    down_ready[u] <= 1'b0;
    err_ready[u] <= 1'b0;
  endtask : collect
  // src 0 primary, 1 second source, 2 both (second left pending)
  task automatic xfer(input int u, input int src, input logic [47:0] va, input logic [9:0] master_id,
                      input logic wr, input int stall);
    @(posedge clock);
    if (src != 0) alt_valid <= 1'b1;
    if (src != 0) alt_req <= '{va, (src == 2) ? ~master_id : master_id, wr};
    if (src != 1) up_valid[u] <= 1'b1;
    if (src != 1) up_req[u] <= '{va, master_id, wr};
    do @(negedge clock); while (!(src == 1 ? alt_ready : up_ready[u]));
    @(posedge clock);
    if (src == 1) alt_valid <= 1'b0;
    else up_valid[u] <= 1'b0;
    collect(u, stall);
  endtask : xfer
  task automatic expect_ok(input int u, input logic [47:0] va, input logic [9:0] master_id, input logic wr);
    logic [43:0] pa;
    dest_type    d;
    pa = {va[43:12] ^ 32'h0000_0101, va[11:0]};
    case (u)
      0: d = dest_coh_s3;
      1: d = dest_coh_s2;
      2: d = dest_coh_s1;
      3: d = (pa[43:20] == `SMMU_MSI_TAG) ? dest_msi : dest_coh_s0;
      4: d = dest_main_feed;
      5: d = (pa[43:32] == `SMMU_MAIN_TAG) ? dest_main_switch : dest_noc_egress;
      default: d = dest_noc_egress;
    endcase
    check(got_err, 1'b0);
    check(seen.pa, pa);
    check(seen.stream_id, {u[4:0], master_id});
    check({seen.write, seen.secure}, {wr, va[16]});
    check(seen.dest, d);
  endtask : expect_ok
  // =========================================
  // scenarios
  task automatic test_units();
    logic [47:0] va;
    int          w;
    for (int pass = 0; pass < 2; pass++) begin
      for (int u = 0; u < 7; u++) begin
        va = {24'h0, 4'(u), 3'b000, u[0], 16'h0ABC};
        w = walks;
        xfer(u, 0, va, 10'h3A0 + 10'(u), u[1], pass);
        expect_ok(u, va, 10'h3A0 + 10'(u), u[1]);
        if (pass == 1) check({lat, walks}, {32'd2, w});
        else check(lat > 2, 1'b1);
      end
    end
    xfer(3, 0, 48'h00FE_0010_1ABC, 10'h011, 1'b1, 0);
    expect_ok(3, 48'h00FE_0010_1ABC, 10'h011, 1'b1);
    xfer(5, 0, 48'h0123_4567_8ABC, 10'h022, 1'b0, 0);
    expect_ok(5, 48'h0123_4567_8ABC, 10'h022, 1'b0);
    $display("test_units done");
  endtask : test_units
  task automatic test_faults();
    xfer(1, 0, 48'h0000_0008_0123, 10'h155, 1'b0, 2);
    check({got_err, einfo}, {1'b1, 10'h155, 1'b0});
    xfer(1, 0, 48'h0000_0004_0123, 10'h156, 1'b1, 0);
    check({got_err, einfo}, {1'b1, 10'h156, 1'b1});
    xfer(1, 0, 48'h0000_0004_0123, 10'h157, 1'b0, 0);
    expect_ok(1, 48'h0000_0004_0123, 10'h157, 1'b0);
    $display("test_faults done");
  endtask : test_faults
  task automatic test_alt();
    xfer(2, 2, 48'h0000_0001_0ABC, 10'h2A5, 1'b0, 0);
    expect_ok(2, 48'h0000_0001_0ABC, 10'h2A5, 1'b0);
    do @(negedge clock); while (!alt_ready);
    @(posedge clock);
    alt_valid <= 1'b0;
    collect(2, 0);
    expect_ok(2, 48'h0000_0001_0ABC, ~10'h2A5, 1'b0);
    xfer(2, 1, 48'h0000_0002_0ABC, 10'h0C3, 1'b1, 1);
    expect_ok(2, 48'h0000_0002_0ABC, 10'h0C3, 1'b1);
    $display("test_alt done");
  endtask : test_alt
  task automatic test_slow();
    @(posedge clock);
    slow <= 1'b1;
    xfer(6, 0, 48'h0000_0005_0ABC, 10'h3FF, 1'b0, 4);
    expect_ok(6, 48'h0000_0005_0ABC, 10'h3FF, 1'b0);
    check(lat > 14, 1'b1);
    slow <= 1'b0;
    $display("test_slow done");
  endtask : test_slow
  // =========================================
  // main sequence and watchdog
  initial begin
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    repeat (4) @(posedge clock);
    test_units();
    test_faults();
    test_alt();
    test_slow();
    finish_test();
  end
  initial begin
    #200000;
    bad_count++;
    finish_test();
  end
endmodule : smmu_two_stage_translation_bench
